// ---- irq_source_select.sv ----
// interrupt pin routing, fifo flags and fill control behind an apb slave
`timescale 1ns/1ps
`include "irq_source_select_cfg.svh"
module irq_source_select
    import irq_source_select_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] data_mode,
    input wire logic tx_active,
    input wire logic addr_filter_en,
    input wire logic sync_det,
    input wire logic rssi_det,
    input wire logic write_byte,
    input wire logic payload_ready,
    input wire logic crc_ok,
    input wire logic addr_match,
    input wire logic recovered_bit_clock,
    input wire logic fifo_full,
    input wire logic fifo_not_empty,
    input wire logic fifo_thresh,
    input wire logic fifo_overrun,
    input wire logic tx_last_bit,
    output logic irq0_pin,
    output logic irq1_pin,
    output logic fifo_flush,
    output logic fifo_fill_en,
    output logic irq
);

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    wire [9:0] word_idx = paddr[11:2];
    wire access = psel & penable;
    wire setup_done = access & ~pready_q;
    wire wr_en = access & pready_q & pwrite;
    wire hit_route = (word_idx == `IRQ_ROUTE_IDX);
    wire hit_fill = (word_idx == `FILL_CFG_IDX);
    wire hit_status = (word_idx == `IRQ_STATUS_IDX);
    wire hit_mask = (word_idx == `IRQ_MASK_IDX);
    wire hit_any = hit_route | hit_fill | hit_status | hit_mask;
    wire wr_route = wr_en & hit_route;
    wire wr_fill = wr_en & hit_fill;
    wire wr_status = wr_en & hit_status;
    wire wr_mask = wr_en & hit_mask;

    // ------------------------------------------------------------
    // configuration and flags
    // ------------------------------------------------------------
    logic [1:0] sel0_q;
    logic [1:0] sel1_q;
    logic tx_sel1_q;
    logic overrun_q;
    logic overrun_d;
    logic flush_q;
    logic method_q;
    logic tx_start_q;
    logic fill_active_q;
    logic fill_active_d;
    logic fill_en_q;
    logic tx_done_q;
    logic tx_done_d;
    logic full_prev_q;
    logic [3:0] status_q;
    logic [3:0] status_d;
    logic [3:0] mask_q;
    logic irq_q;
    logic irq0_q;
    logic irq1_q;
    wire pin0_d;
    wire pin1_d;

    wire is_buf = (decode_mode(data_mode) == MODE_BUFFERED);
    // method bit only steers buffered mode
    wire manual_fill = is_buf & method_q;
    wire overrun_clr = wr_route & pwdata[`ROUTE_OVERRUN];
    wire fill_clr = wr_fill & pwdata[`FILL_CTRL];

    // overrun set wins over a simultaneous clear
    assign overrun_d = fifo_overrun | (overrun_q & ~overrun_clr);
    // transmit done held until transmit ends
    assign tx_done_d = tx_active & (tx_done_q | tx_last_bit);

    // auto fill starts on sync, manual fill follows the host bit
    always_comb begin
        fill_active_d = fill_active_q;
        if (manual_fill) begin
            if (wr_fill) begin
                fill_active_d = pwdata[`FILL_CTRL];
            end
        end else begin
            fill_active_d = sync_det | (fill_active_q & ~fill_clr);
        end
    end

    wire [3:0] events = {fifo_full & ~full_prev_q, sync_det, tx_active & tx_last_bit,
                         fifo_overrun};
    wire [3:0] st_clr = wr_status ? pwdata[3:0] : 4'h0;
    assign status_d = events | (status_q & ~st_clr);

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // live fifo flags read through the route register
    wire [7:0] route_rd = {sel0_q, sel1_q, tx_sel1_q, fifo_full, fifo_not_empty, overrun_q};
    wire [7:0] fill_rd = {method_q, fill_active_q, tx_done_q, tx_start_q, 4'h0};
    wire [31:0] rd_data = hit_route ? {24'h0, route_rd} :
                          hit_fill ? {24'h0, fill_rd} :
                          hit_status ? {28'h0, status_q} :
                          hit_mask ? {28'h0, mask_q} : 32'h0;

    // ------------------------------------------------------------
    // source routing
    // ------------------------------------------------------------
    // pin selection
    irq_route_mux u_mux (
        .data_mode(data_mode),
        .tx_active(tx_active),
        .sel0(sel0_q),
        .sel1(sel1_q),
        .tx_sel1(tx_sel1_q),
        .tx_start_sel(tx_start_q),
        .sync_det(sync_det),
        .rssi_det(rssi_det),
        .write_byte(write_byte),
        .payload_ready(payload_ready),
        .crc_ok(crc_ok),
        .addr_match(addr_match),
        .addr_filter_en(addr_filter_en),
        .recovered_bit_clock(recovered_bit_clock),
        .fifo_full(fifo_full),
        .fifo_not_empty(fifo_not_empty),
        .fifo_thresh(fifo_thresh),
        .tx_done(tx_done_q),
        .pin0(pin0_d),
        .pin1(pin1_d)
    );

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // one wait state: the answer comes in the second access cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else if (ce) begin
            pready_q <= setup_done;
            pslverr_q <= setup_done & ~hit_any;
            prdata_q <= setup_done ? rd_data : 32'h0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            sel0_q <= `SEL_RESET;
            sel1_q <= `SEL_RESET;
            tx_sel1_q <= `BIT_RESET;
            method_q <= `BIT_RESET;
            tx_start_q <= `BIT_RESET;
            mask_q <= `ST_RESET;
        end else if (ce) begin
            if (wr_route) begin
                sel0_q <= pwdata[`ROUTE_SEL0_HI:`ROUTE_SEL0_LO];
                sel1_q <= pwdata[`ROUTE_SEL1_HI:`ROUTE_SEL1_LO];
                tx_sel1_q <= pwdata[`ROUTE_TX_SEL1];
            end
            if (wr_fill) begin
                method_q <= pwdata[`FILL_METHOD];
                tx_start_q <= pwdata[`FILL_TX_START];
            end
            if (wr_mask) begin
                mask_q <= pwdata[3:0];
            end
        end
    end

    // flags and pins registered on the clock
    always_ff @(posedge core_clk) begin
        if (srst) begin
            overrun_q <= 1'b0;
            flush_q <= 1'b0;
            fill_active_q <= 1'b0;
            fill_en_q <= 1'b0;
            tx_done_q <= 1'b0;
            full_prev_q <= 1'b0;
            status_q <= `ST_RESET;
            irq_q <= 1'b0;
            irq0_q <= 1'b0;
            irq1_q <= 1'b0;
        end else if (ce) begin
            overrun_q <= overrun_d;
            // flush pulse on a written one
            flush_q <= overrun_clr;
            fill_active_q <= fill_active_d;
            fill_en_q <= fill_active_d;
            tx_done_q <= tx_done_d;
            full_prev_q <= fifo_full;
            status_q <= status_d;
            irq_q <= |(status_d & mask_q);
            irq0_q <= pin0_d;
            irq1_q <= pin1_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq0_pin = irq0_q;
    assign irq1_pin = irq1_q;
    assign fifo_flush = flush_q;
    assign fifo_fill_en = fill_en_q;
    assign irq = irq_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    wire rx_side = ~tx_active;
    wire is_cont = (data_mode == 2'h0);

    chk_cont_rssi_pin0: assert property (
        ce && rx_side && is_cont && sel0_q == 2'h1 |=> irq0_q == $past(rssi_det))
        else $error("pin zero not signal strength in continuous mode");
    chk_buf_pin0_none: assert property (
        ce && rx_side && is_buf && sel0_q == 2'h0 |=> !irq0_q)
        else $error("pin zero active with no source selected");
    chk_pkt_addr_match: assert property (
        ce && rx_side && data_mode[1] && sel0_q == 2'h3 && addr_filter_en
        |=> irq0_q == $past(addr_match))
        else $error("pin zero not address match");
    chk_cont_clock_pin1: assert property (
        ce && rx_side && is_cont |=> irq1_q == $past(recovered_bit_clock))
        else $error("pin one not bit clock in continuous mode");
    chk_pkt_crc_pin1: assert property (
        ce && rx_side && data_mode[1] && sel1_q == 2'h0 |=> irq1_q == $past(crc_ok))
        else $error("pin one not checksum ok");
    chk_tx_done_pin1: assert property (
        ce && tx_active && !is_cont && tx_sel1_q |=> irq1_q == $past(tx_done_q))
        else $error("pin one not transmit done");
    chk_full_readback: assert property (
        ce && setup_done && hit_route |=> prdata_q[2] == $past(fifo_full))
        else $error("full bit read back wrong");
    chk_empty_readback: assert property (
        ce && setup_done && hit_route |=> prdata_q[1] == $past(fifo_not_empty))
        else $error("not-empty bit read back wrong");
    chk_overrun_clear: assert property (
        ce && overrun_clr && !fifo_overrun
        |=> !overrun_q && fifo_flush ##1 (!fifo_flush || !$past(ce)))
        else $error("overrun clear or flush wrong");
    chk_fill_auto: assert property (
        ce && !manual_fill && sync_det |=> fill_active_q && fifo_fill_en)
        else $error("auto fill not started on sync");
    chk_tx_done_set: assert property (
        ce && tx_active && tx_last_bit |=> tx_done_q)
        else $error("transmit done not set");
    chk_fill_manual: assert property (
        ce && manual_fill && wr_fill |=> fill_active_q == $past(pwdata[`FILL_CTRL]))
        else $error("manual fill not the written value");
    chk_not_empty_pin0: assert property (
        ce && rx_side && !is_cont && sel0_q == 2'h2 |=> irq0_q == $past(fifo_not_empty))
        else $error("pin zero not the not-empty flag");
    chk_sel_reset: assert property (
        $past(srst) |-> sel0_q == 2'h0 && sel1_q == 2'h0 && !tx_sel1_q)
        else $error("selects not zero after reset");

    cov_overrun_flush: cover property (ce && overrun_q ##[1:20] fifo_flush);
    cov_irq_raise: cover property (!irq_q ##1 irq_q);
    cov_pkt_route: cover property (ce && data_mode[1] && rx_side && sel0_q == 2'h3 && irq0_q);

endmodule : irq_source_select

// ---- irq_source_select_cfg.svh ----
// register map, field positions and reset values of the interrupt source select block
`ifndef IRQ_SOURCE_SELECT_CFG_SVH
`define IRQ_SOURCE_SELECT_CFG_SVH

// register indices; byte address is four times the index
`define IRQ_ROUTE_IDX 10'h00d
`define FILL_CFG_IDX 10'h00e
`define IRQ_STATUS_IDX 10'h010
`define IRQ_MASK_IDX 10'h011

// interrupt_route_config fields
`define ROUTE_SEL0_HI 7
`define ROUTE_SEL0_LO 6
`define ROUTE_SEL1_HI 5
`define ROUTE_SEL1_LO 4
`define ROUTE_TX_SEL1 3
`define ROUTE_FULL 2
`define ROUTE_NOT_EMPTY 1
`define ROUTE_OVERRUN 0

// fifo_fill_config fields
`define FILL_METHOD 7
`define FILL_CTRL 6
`define FILL_TX_DONE 5
`define FILL_TX_START 4

// interrupt status and mask bits
`define ST_OVERRUN 0
`define ST_TX_DONE 1
`define ST_SYNC 2
`define ST_FULL 3
`define ST_WIDTH 4

`define SEL_RESET 2'h0
`define BIT_RESET 1'h0
`define ST_RESET 4'h0

`endif

// ---- irq_source_select_pkg.sv ----
// types and mode decoding shared by the interrupt source select block
package irq_source_select_pkg;

    typedef enum logic [1:0] {
        MODE_CONTINUOUS,
        MODE_BUFFERED,
        MODE_PACKET
    } data_mode_e;

    // any code with the upper bit set is packet mode
    function automatic data_mode_e decode_mode(input logic [1:0] code);
        decode_mode = code[1] ? MODE_PACKET : (code[0] ? MODE_BUFFERED : MODE_CONTINUOUS);
    endfunction : decode_mode

endpackage : irq_source_select_pkg

// ---- irq_route_mux.sv ----
// combinational source selection for the two interrupt pins
`timescale 1ns/1ps
module irq_route_mux
    import irq_source_select_pkg::*;
(
    input wire logic [1:0] data_mode,
    input wire logic tx_active,
    input wire logic [1:0] sel0,
    input wire logic [1:0] sel1,
    input wire logic tx_sel1,
    input wire logic tx_start_sel,
    input wire logic sync_det,
    input wire logic rssi_det,
    input wire logic write_byte,
    input wire logic payload_ready,
    input wire logic crc_ok,
    input wire logic addr_match,
    input wire logic addr_filter_en,
    input wire logic recovered_bit_clock,
    input wire logic fifo_full,
    input wire logic fifo_not_empty,
    input wire logic fifo_thresh,
    input wire logic tx_done,
    output logic pin0,
    output logic pin1
);

    data_mode_e mode;
    logic pkt_match;

    assign mode = decode_mode(data_mode);
    // address match replaces sync only when filtering is on
    assign pkt_match = addr_filter_en ? addr_match : sync_det;

    always_comb begin
        pin0 = 1'b0;
        pin1 = 1'b0;
        if (tx_active) begin
            unique case (mode)
                MODE_CONTINUOUS: begin
                    pin1 = recovered_bit_clock;
                end
                MODE_BUFFERED: begin
                    pin0 = fifo_not_empty;
                    pin1 = tx_sel1 ? tx_done : fifo_full;
                end
                MODE_PACKET: begin
                    pin0 = tx_start_sel ? fifo_not_empty : fifo_thresh;
                    pin1 = tx_sel1 ? tx_done : fifo_full;
                end
            endcase
        end else begin
            unique case (mode)
                MODE_CONTINUOUS: begin
                    pin0 = (sel0 == 2'h1) ? rssi_det : sync_det;
                    pin1 = recovered_bit_clock;
                end
                MODE_BUFFERED: begin
                    unique case (sel0)
                        2'h0: pin0 = 1'b0;
                        2'h1: pin0 = write_byte;
                        2'h2: pin0 = fifo_not_empty;
                        2'h3: pin0 = sync_det;
                    endcase
                    unique case (sel1)
                        2'h0: pin1 = 1'b0;
                        2'h1: pin1 = fifo_full;
                        2'h2: pin1 = rssi_det;
                        2'h3: pin1 = fifo_thresh;
                    endcase
                end
                MODE_PACKET: begin
                    unique case (sel0)
                        2'h0: pin0 = payload_ready;
                        2'h1: pin0 = write_byte;
                        2'h2: pin0 = fifo_not_empty;
                        2'h3: pin0 = pkt_match;
                    endcase
                    unique case (sel1)
                        2'h0: pin1 = crc_ok;
                        2'h1: pin1 = fifo_full;
                        2'h2: pin1 = rssi_det;
                        2'h3: pin1 = fifo_thresh;
                    endcase
                end
            endcase
        end
    end

endmodule : irq_route_mux

// ---- apb_host.sv ----
// apb master model of the host that programs the interrupt router
`timescale 1ns/1ps
module apb_host (
    input wire logic core_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end

    // answer taken at the edge that samples pready high; a hang is left to the watchdog
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        r = 'x;
        e = 1'bx;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : apb_host

// ---- irq_source_select_test.sv ----
// self-checking bench for the interrupt source select block
`timescale 1ns/1ps
`include "irq_source_select_cfg.svh"
module irq_source_select_test;
    import irq_source_select_pkg::*;
    localparam logic [11:0] a_route = {`IRQ_ROUTE_IDX, 2'b00};
    localparam logic [11:0] a_fill = {`FILL_CFG_IDX, 2'b00};
    localparam logic [11:0] a_stat = {`IRQ_STATUS_IDX, 2'b00};
    localparam logic [11:0] a_mask = {`IRQ_MASK_IDX, 2'b00};
    logic core_clk, srst, ce, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0] data_mode;
    logic tx_active, addr_filter_en, sync_det, rssi_det, write_byte, payload_ready;
    logic crc_ok, addr_match, recovered_bit_clock, fifo_full, fifo_not_empty;
    logic fifo_thresh, fifo_overrun, tx_last_bit;
    logic irq0_pin, irq1_pin, fifo_flush, fifo_fill_en, irq;
    int mismatches = 0;
    int n_compared = 0;

    apb_host apb_host_i (.core_clk(core_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    irq_source_select irq_source_select_i (.core_clk(core_clk), .srst(srst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .data_mode(data_mode), .tx_active(tx_active), .addr_filter_en(addr_filter_en),
        .sync_det(sync_det), .rssi_det(rssi_det), .write_byte(write_byte),
        .payload_ready(payload_ready), .crc_ok(crc_ok), .addr_match(addr_match),
        .recovered_bit_clock(recovered_bit_clock), .fifo_full(fifo_full),
        .fifo_not_empty(fifo_not_empty), .fifo_thresh(fifo_thresh),
        .fifo_overrun(fifo_overrun), .tx_last_bit(tx_last_bit), .irq0_pin(irq0_pin),
        .irq1_pin(irq1_pin), .fifo_flush(fifo_flush), .fifo_fill_en(fifo_fill_en),
        .irq(irq));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb_host_i.xfer(1'b1, a, d, r, e);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        logic e;
        apb_host_i.xfer(1'b0, a, 32'h0, r, e);
        chk(r, exp, what);
    endtask : rdc

    // sources one-hot: 0 sync .. 9 threshold; pins lag one cycle
    task automatic set_src(input logic [9:0] v);
        @(posedge core_clk);
        {fifo_thresh, fifo_not_empty, fifo_full, recovered_bit_clock, addr_match, crc_ok,
         payload_ready, write_byte, rssi_det, sync_det} <= v;
        repeat (2) @(posedge core_clk);
        #1;
    endtask : set_src

    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask : settle

    task automatic pulse_sync();
        @(posedge core_clk);
        sync_det <= 1'b1;
        @(posedge core_clk);
        sync_det <= 1'b0;
    endtask : pulse_sync

    // index of the source expected on a pin, -1 for none, 10 for transmit done
    function automatic int exp_src(int pin, int m, int tx, int af, int s);
        if (pin == 0) begin
            if (tx != 0) return (m == 0) ? -1 : ((m == 1) ? 8 : 9);
            if (m == 0) return (s == 1) ? 1 : 0;
            case (s)
                0: return (m == 1) ? -1 : 3;
                1: return 2;
                2: return 8;
                default: return (m > 1 && af != 0) ? 5 : 0;
            endcase
        end
        if (m == 0) return 6;
        if (tx != 0) return (s % 2 != 0) ? 10 : 7;
        case (s)
            0: return (m == 1) ? -1 : 4;
            1: return 7;
            2: return 1;
            default: return 9;
        endcase
    endfunction : exp_src

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reset();
        rdc(a_route, 32'h0, "route after reset");
        rdc(a_mask, 32'h0, "mask after reset");
        chk({27'h0, irq0_pin, irq1_pin, fifo_flush, fifo_fill_en, irq}, 32'h0, "outs");
        $display("reset test done");
    endtask : test_reset

    task automatic test_routing();
        int e0;
        int e1;
        for (int tx = 0; tx < 2; tx++)
        for (int m = 0; m < 4; m++)
        for (int af = 0; af < 2; af++)
        for (int s = 0; s < 4; s++) begin
            @(posedge core_clk);
            tx_active <= tx[0];
            data_mode <= m[1:0];
            addr_filter_en <= af[0];
            wr(a_route, {24'h0, s[1:0], s[1:0], s[0], 3'b000});
            e0 = exp_src(0, m, tx, af, s);
            e1 = exp_src(1, m, tx, af, s);
            for (int k = 0; k < 10; k++) begin
                set_src(10'h001 << k);
                chk({31'h0, irq0_pin}, {31'h0, e0 == k}, "pin zero");
                chk({31'h0, irq1_pin}, {31'h0, e1 == k}, "pin one");
            end
        end
        set_src(10'h000);
        @(posedge core_clk);
        tx_active <= 1'b0;
        $display("routing test done");
    endtask : test_routing

    task automatic test_flags();
        int n;
        wr(a_route, 32'h0);
        set_src(10'h180);
        rdc(a_route, 32'h6, "full and not empty");
        set_src(10'h000);
        rdc(a_route, 32'h0, "empty");
        @(posedge core_clk);
        fifo_overrun <= 1'b1;
        @(posedge core_clk);
        fifo_overrun <= 1'b0;
        rdc(a_route, 32'h1, "overrun set");
        wr(a_route, 32'h1);
        #1;
        n = (fifo_flush === 1'b1);
        repeat (3) begin
            @(posedge core_clk);
            #1;
            n += (fifo_flush === 1'b1);
        end
        chk(n, 1, "flush pulses");
        rdc(a_route, 32'h0, "overrun cleared");
        @(posedge core_clk);
        ce <= 1'b0;
        fifo_overrun <= 1'b1;
        @(posedge core_clk);
        fifo_overrun <= 1'b0;
        ce <= 1'b1;
        // an overrun while frozen is not taken
        rdc(a_route, 32'h0, "frozen overrun");
        $display("flags test done");
    endtask : test_flags

    task automatic test_irq();
        logic [31:0] r;
        logic e;
        wr(a_stat, 32'hf);
        wr(a_mask, 32'h0);
        pulse_sync();
        rdc(a_stat, 32'h4, "sync status");
        chk({31'h0, irq}, 32'h0, "masked irq");
        wr(a_mask, 32'h4);
        settle();
        chk({31'h0, irq}, 32'h1, "unmasked irq");
        wr(a_stat, 32'h4);
        settle();
        chk({31'h0, irq}, 32'h0, "cleared irq");
        // unmapped word is refused
        apb_host_i.xfer(1'b0, 12'h050, 32'h0, r, e);
        chk({r[31:1], e}, 32'h1, "unmapped read");
        $display("interrupt test done");
    endtask : test_irq

    task automatic test_fill();
        @(posedge core_clk);
        data_mode <= 2'b01;
        wr(a_fill, 32'h40);
        settle();
        chk({31'h0, fifo_fill_en}, 32'h0, "fill cleared");
        pulse_sync();
        settle();
        chk({31'h0, fifo_fill_en}, 32'h1, "auto fill");
        // the method bit steers the writes after it, not its own
        wr(a_fill, 32'h80);
        wr(a_fill, 32'h80);
        settle();
        chk({31'h0, fifo_fill_en}, 32'h0, "manual stop");
        wr(a_fill, 32'hc0);
        settle();
        chk({31'h0, fifo_fill_en}, 32'h1, "manual start");
        wr(a_fill, 32'h80);
        pulse_sync();
        settle();
        chk({31'h0, fifo_fill_en}, 32'h0, "manual ignores sync");
        @(posedge core_clk);
        data_mode <= 2'b10;
        pulse_sync();
        settle();
        chk({31'h0, fifo_fill_en}, 32'h1, "packet auto fill");
        $display("fill test done");
    endtask : test_fill

    task automatic test_tx_done();
        wr(a_stat, 32'hf);
        tx_active <= 1'b1;
        @(posedge core_clk);
        tx_last_bit <= 1'b1;
        @(posedge core_clk);
        tx_last_bit <= 1'b0;
        rdc(a_stat, 32'h2, "tx done status");
        wr(a_route, 32'h08);
        settle();
        chk({31'h0, irq1_pin}, 32'h1, "tx done on pin one");
        // transmit pin zero follows not-empty once the start bit is set
        wr(a_fill, 32'h10);
        set_src(10'h100);
        chk({31'h0, irq0_pin}, 32'h1, "tx start pin zero");
        set_src(10'h000);
        @(posedge core_clk);
        tx_active <= 1'b0;
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        // a second reset restores the defaults
        rdc(a_route, 32'h0, "route after second reset");
        rdc(a_fill, 32'h0, "fill after second reset");
        $display("transmit done test done");
    endtask : test_tx_done

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // routing sweep is about 2240 cycles; the rest is small
    initial begin
        #100000;
        mismatches++;
        give_verdict();
    end

    initial begin
        srst = 1'b1;
        ce = 1'b1;
        data_mode = 2'b00;
        tx_active = 1'b0;
        addr_filter_en = 1'b0;
        {fifo_thresh, fifo_not_empty, fifo_full, recovered_bit_clock, addr_match, crc_ok,
         payload_ready, write_byte, rssi_det, sync_det} = 10'h000;
        fifo_overrun = 1'b0;
        tx_last_bit = 1'b0;
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        #1;
        test_reset();
        test_routing();
        test_flags();
        test_irq();
        test_fill();
        test_tx_done();
        give_verdict();
    end
endmodule : irq_source_select_test
